// file: charger_cfg_defines.svh
// constants for the charger configuration and interrupt mask bank
// assumes inclusion by the design modules, the host model and the bench
`ifndef CHARGER_CFG_DEFINES_SVH
`define CHARGER_CFG_DEFINES_SVH

// register offsets on the serial port
`define OFF_IRQ_MASK      8'h07
`define OFF_TEMP_THRESH   8'h20
`define OFF_INPUT_LIMITS  8'h21
`define OFF_PRECHG_TERM   8'h22

// register reset values
`define RST_IRQ_MASK      8'h7F
`define RST_TEMP_THRESH   8'h0F
`define RST_INPUT_LIMITS  8'h00
`define RST_PRECHG_TERM   8'hF8

// field positions
`define BIT_LOOP_DIS      7
`define BIT_PQ_CURRENT    1
`define BIT_CHARGER_ENABLE        0

// serial slave address, arbitrary value
`define I2C_DEV_ADDR      7'h48

// decode bases and steps
`define HOT_BASE_C        45
`define WARM_BASE_C       35
`define COOL_BASE_C       0
`define COLD_BASE_C       (-10)
`define TEMP_STEP_C       5
`define VMIN_BASE_DV      40
`define VPQ_BASE_DV       23
`define ILIM_MAX_MA       475
`define ILIM_STEP_MA      95
`define ILIM_LAST_CODE    3'h4
`define ILIM_MIN_MA       95
`define PQ_LOW_PCT        10
`define PQ_HIGH_PCT       20
`define TERM_00_PM        50
`define TERM_01_PM        75
`define TERM_10_PM        100
`define TERM_11_PM        150
`define TOPOFF_STEP_MIN   5

`endif

// file: charger_cfg_pkg.sv
// types of the charger configuration bank and its serial port
// assumes the defines header is compiled alongside
package charger_cfg_pkg;

  // serial slave states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } i2c_state_t;

  // serial slave state
  typedef struct packed {
    logic       scl_m;
    logic       scl_s;
    logic       scl_p;
    logic       sda_m;
    logic       sda_s;
    logic       sda_p;
    i2c_state_t state;
    logic [2:0] bitcnt;
    logic       full;
    logic [7:0] shreg;
    logic       rw;
    logic [7:0] ptr;
    logic       oe_b;
    logic       wr_stb;
    logic [7:0] wr_data;
  } i2c_reg_t;

  // register bank state and decoded settings
  typedef struct packed {
    logic [7:0]        mask;
    logic [7:0]        cfg_a;
    logic [7:0]        cfg_b;
    logic [7:0]        cfg_c;
    logic              otp_loaded;
    logic              irq;
    logic              sda_out;
    logic signed [7:0] hot_c;
    logic signed [7:0] warm_c;
    logic signed [7:0] cool_c;
    logic signed [7:0] cold_c;
    logic [5:0]        vmin_dv;
    logic [8:0]        ilim_ma;
    logic [4:0]        pq_pct;
    logic [4:0]        vpq_dv;
    logic [7:0]        term_pm;
    logic [5:0]        topoff_min;
  } bank_reg_t;

endpackage

// file: i2c_reg_port.sv
// serial slave giving byte access to the register bank
// assumes raw scl/sda pins, pointer auto-increments per byte
`timescale 1ns/100ps
`include "charger_cfg_defines.svh"

module i2c_reg_port
  import charger_cfg_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_oe_b,
  // register side
  input  wire logic [7:0] i_rd_data,
  output logic [7:0]      o_ptr,
  output logic            o_wr_stb,
  output logic [7:0]      o_wr_data
);

  i2c_reg_t q;
  i2c_reg_t next_q;
  logic     rise;
  logic     fall;
  logic     start;
  logic     stop;

  // line events from synchronised copies
  assign rise  = q.scl_s & ~q.scl_p;
  assign fall  = ~q.scl_s & q.scl_p;
  assign start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
  assign stop  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;

  // protocol sequencing
  always_comb begin
    next_q        = q;
    next_q.scl_m  = i_scl;
    next_q.scl_s  = q.scl_m;
    next_q.scl_p  = q.scl_s;
    next_q.sda_m  = i_sda;
    next_q.sda_s  = q.sda_m;
    next_q.sda_p  = q.sda_s;
    next_q.wr_stb = 1'b0;
    if (start) begin
      next_q.state  = ST_ADDR;
      next_q.bitcnt = 3'h0;
      next_q.full   = 1'b0;
      next_q.oe_b   = 1'b1;
    end else if (stop) begin
      next_q.state = ST_IDLE;
      next_q.oe_b  = 1'b1;
    end else if (rise) begin
      case (q.state)
        ST_ADDR, ST_PTR, ST_WR, ST_RD: begin
          if (q.state != ST_RD) begin
            next_q.shreg = {q.shreg[6:0], q.sda_s};
          end
          next_q.bitcnt = q.bitcnt + 3'h1;
          next_q.full   = (q.bitcnt == 3'h7);
        end
        ST_RD_ACK: begin
          if (q.sda_s) begin
            next_q.state = ST_IDLE; // master nack ends the read
          end
        end
        default: ;
      endcase
    end else if (fall) begin
      case (q.state)
        ST_ADDR: begin
          if (q.full) begin
            next_q.full = 1'b0;
            if (q.shreg[7:1] == `I2C_DEV_ADDR) begin
              next_q.oe_b  = 1'b0;
              next_q.rw    = q.shreg[0];
              next_q.state = ST_ADDR_ACK;
            end else begin
              next_q.state = ST_IDLE;
            end
          end
        end
        ST_PTR: begin
          if (q.full) begin
            next_q.full  = 1'b0;
            next_q.ptr   = q.shreg;
            next_q.oe_b  = 1'b0;
            next_q.state = ST_PTR_ACK;
          end
        end
        ST_WR: begin
          if (q.full) begin
            next_q.full    = 1'b0;
            next_q.wr_stb  = 1'b1;
            next_q.wr_data = q.shreg;
            next_q.oe_b    = 1'b0;
            next_q.state   = ST_WR_ACK;
          end
        end
        ST_RD: begin
          if (q.full) begin
            next_q.full  = 1'b0;
            next_q.oe_b  = 1'b1;
            next_q.ptr   = q.ptr + 8'h01;
            next_q.state = ST_RD_ACK;
          end else begin
            next_q.shreg = {q.shreg[6:0], 1'b0};
            next_q.oe_b  = q.shreg[6];
          end
        end
        ST_ADDR_ACK: begin
          if (q.rw) begin
            next_q.shreg = i_rd_data;
            next_q.oe_b  = i_rd_data[7];
            next_q.state = ST_RD;
          end else begin
            next_q.oe_b  = 1'b1;
            next_q.state = ST_PTR;
          end
        end
        ST_PTR_ACK: begin
          next_q.oe_b  = 1'b1;
          next_q.state = ST_WR;
        end
        ST_WR_ACK: begin
          next_q.oe_b  = 1'b1;
          next_q.ptr   = q.ptr + 8'h01;
          next_q.state = ST_WR;
        end
        ST_RD_ACK: begin
          next_q.shreg = i_rd_data;
          next_q.oe_b  = i_rd_data[7];
          next_q.state = ST_RD;
        end
        default: ;
      endcase
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '{scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1, sda_m: 1'b1,
             sda_s: 1'b1, sda_p: 1'b1, state: ST_IDLE, bitcnt: 3'h0,
             full: 1'b0, shreg: 8'h00, rw: 1'b0, ptr: 8'h00,
             oe_b: 1'b1, wr_stb: 1'b0, wr_data: 8'h00};
    end else begin
      q <= next_q;
    end
  end

  assign o_sda_oe_b = q.oe_b;
  assign o_ptr      = q.ptr;
  assign o_wr_stb   = q.wr_stb;
  assign o_wr_data  = q.wr_data;

endmodule

// file: charger_config_irq_mask_regs.sv
// charger interrupt mask and configuration registers behind a serial port
// assumes event flags arrive on the system clock, pins are asynchronous
//
// Behaviour
// - a set mask bit keeps its event flag off the interrupt output
// - mask register bit 7 disables the input current loop, reset 0
// - hot limit code maps to 45, 50, 55, 60 degrees
// - warm limit code maps to 35, 40, 45, 50 degrees
// - cool limit code maps to 0, 5, 10, 15 degrees
// - cold limit code maps to -10, -5, 0, 5 degrees
// - minimum input voltage code maps linearly 4.0 V to 4.7 V
// - input current limit 475 down to 95 mA, codes above 4 act as 4
// - precharge current select gives 10 or 20 percent of fast charge
// - charger enable bit, reset value taken from the one-time default
// - precharge voltage code maps 2.3 V to 3.0 V, reset code 111
// - termination code gives 5, 7.5, 10, 15 percent of fast charge
// - top-off code gives 0 to 35 minutes in 5 minute steps, reset 0
`timescale 1ns/100ps
`include "charger_cfg_defines.svh"

module charger_config_irq_mask_regs
  import charger_cfg_pkg::*;
(
  // clock and reset
  input  wire logic              I_SYS_CLK,
  input  wire logic              I_RST_B,
  // serial pins
  input  wire logic              I_SCL,
  input  wire logic              I_SDA,
  output logic                   O_SDA_OUT,
  output logic                   O_SDA_OE_B,
  // event flags and one-time default
  input  wire logic [6:0]        I_EVENT_FLAGS,
  input  wire logic              I_CHARGER_ENABLE_OTP_DEFAULT,
  // interrupt and controls
  output logic                   O_IRQ,
  output logic                   O_INPUT_LOOP_DISABLE,
  output logic                   O_CHARGER_ENABLE,
  // decoded settings
  output logic signed [7:0]      O_HOT_LIMIT_C,
  output logic signed [7:0]      O_WARM_LIMIT_C,
  output logic signed [7:0]      O_COOL_LIMIT_C,
  output logic signed [7:0]      O_COLD_LIMIT_C,
  output logic [5:0]             O_INPUT_MIN_VOLTAGE_DV,
  output logic [8:0]             O_INPUT_CURRENT_LIMIT_MA,
  output logic [4:0]             O_PRECHARGE_CURRENT_PCT,
  output logic [4:0]             O_PRECHARGE_VOLTAGE_DV,
  output logic [7:0]             O_TERM_CURRENT_PERMILLE,
  output logic [5:0]             O_TOPOFF_MINUTES
);

  localparam bank_reg_t BANK_RESET = '{
    mask: `RST_IRQ_MASK, cfg_a: `RST_TEMP_THRESH,
    cfg_b: `RST_INPUT_LIMITS, cfg_c: `RST_PRECHG_TERM,
    otp_loaded: 1'b0, irq: 1'b0, sda_out: 1'b0,
    hot_c: 8'sd45, warm_c: 8'sd35, cool_c: 8'sd15, cold_c: 8'sd5,
    vmin_dv: 6'd40, ilim_ma: 9'd475, pq_pct: 5'd10, vpq_dv: 5'd30,
    term_pm: 8'd150, topoff_min: 6'd0};

  logic       rst_b_meta;
  logic       rst_b_sync;
  logic [7:0] ptr;
  logic       wr_stb;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  bank_reg_t  q;
  bank_reg_t  next_q;

  // reset release through two flops
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_b_meta <= 1'b0;
      rst_b_sync <= 1'b0;
    end else begin
      rst_b_meta <= 1'b1;
      rst_b_sync <= rst_b_meta;
    end
  end

  // serial byte port
  i2c_reg_port u_port (
    .i_clk      (I_SYS_CLK),
    .i_rst_b    (rst_b_sync),
    .i_scl      (I_SCL),
    .i_sda      (I_SDA),
    .o_sda_oe_b (O_SDA_OE_B),
    .i_rd_data  (rd_data),
    .o_ptr      (ptr),
    .o_wr_stb   (wr_stb),
    .o_wr_data  (wr_data)
  );

  // read mux, unmapped offsets read zero
  always_comb begin
    if (ptr == `OFF_IRQ_MASK) begin
      rd_data = q.mask;
    end else if (ptr == `OFF_TEMP_THRESH) begin
      rd_data = q.cfg_a;
    end else if (ptr == `OFF_INPUT_LIMITS) begin
      rd_data = q.cfg_b;
    end else if (ptr == `OFF_PRECHG_TERM) begin
      rd_data = q.cfg_c;
    end else begin
      rd_data = 8'h00;
    end
  end

  // register writes, interrupt gating and setting decode
  always_comb begin
    next_q            = q;
    next_q.otp_loaded = 1'b1;
    next_q.sda_out    = 1'b0;
    if (wr_stb) begin
      if (ptr == `OFF_IRQ_MASK) begin
        next_q.mask = wr_data;
      end else if (ptr == `OFF_TEMP_THRESH) begin
        next_q.cfg_a = wr_data;
      end else if (ptr == `OFF_INPUT_LIMITS) begin
        next_q.cfg_b = wr_data;
      end else if (ptr == `OFF_PRECHG_TERM) begin
        next_q.cfg_c = wr_data;
      end
    end
    if (!q.otp_loaded) begin
      next_q.cfg_b[`BIT_CHARGER_ENABLE] = I_CHARGER_ENABLE_OTP_DEFAULT;
    end
    next_q.irq = |(I_EVENT_FLAGS & ~q.mask[6:0]);
    next_q.hot_c = 8'(`HOT_BASE_C
      + `TEMP_STEP_C * int'(q.cfg_a[7:6]));
    next_q.warm_c = 8'(`WARM_BASE_C
      + `TEMP_STEP_C * int'(q.cfg_a[5:4]));
    next_q.cool_c = 8'(`COOL_BASE_C
      + `TEMP_STEP_C * int'(q.cfg_a[3:2]));
    next_q.cold_c = 8'(`COLD_BASE_C
      + `TEMP_STEP_C * int'(q.cfg_a[1:0]));
    next_q.vmin_dv = 6'(`VMIN_BASE_DV + int'(q.cfg_b[7:5]));
    if (q.cfg_b[4:2] >= `ILIM_LAST_CODE) begin
      next_q.ilim_ma = 9'(`ILIM_MIN_MA);
    end else begin
      next_q.ilim_ma = 9'(`ILIM_MAX_MA
        - `ILIM_STEP_MA * int'(q.cfg_b[4:2]));
    end
    next_q.pq_pct = q.cfg_b[`BIT_PQ_CURRENT] ? 5'(`PQ_HIGH_PCT)
                                             : 5'(`PQ_LOW_PCT);
    next_q.vpq_dv = 5'(`VPQ_BASE_DV + int'(q.cfg_c[7:5]));
    case (q.cfg_c[4:3])
      2'h0:    next_q.term_pm = 8'(`TERM_00_PM);
      2'h1:    next_q.term_pm = 8'(`TERM_01_PM);
      2'h2:    next_q.term_pm = 8'(`TERM_10_PM);
      default: next_q.term_pm = 8'(`TERM_11_PM);
    endcase
    next_q.topoff_min = 6'(`TOPOFF_STEP_MIN * int'(q.cfg_c[2:0]));
  end

  // bank register
  always_ff @(posedge I_SYS_CLK or negedge rst_b_sync) begin
    if (!rst_b_sync) begin
      q <= BANK_RESET;
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from flops
  assign O_SDA_OUT                = q.sda_out;
  assign O_IRQ                    = q.irq;
  assign O_INPUT_LOOP_DISABLE     = q.mask[`BIT_LOOP_DIS];
  assign O_CHARGER_ENABLE         = q.cfg_b[`BIT_CHARGER_ENABLE];
  assign O_HOT_LIMIT_C            = q.hot_c;
  assign O_WARM_LIMIT_C           = q.warm_c;
  assign O_COOL_LIMIT_C           = q.cool_c;
  assign O_COLD_LIMIT_C           = q.cold_c;
  assign O_INPUT_MIN_VOLTAGE_DV   = q.vmin_dv;
  assign O_INPUT_CURRENT_LIMIT_MA = q.ilim_ma;
  assign O_PRECHARGE_CURRENT_PCT  = q.pq_pct;
  assign O_PRECHARGE_VOLTAGE_DV   = q.vpq_dv;
  assign O_TERM_CURRENT_PERMILLE  = q.term_pm;
  assign O_TOPOFF_MINUTES         = q.topoff_min;

  // checks on the bank
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!rst_b_sync);

  masked_quiet_a: assert property (
    ((I_EVENT_FLAGS & ~q.mask[6:0]) == 7'h00) |=> !O_IRQ)
    else $error("masked flag raised interrupt");
  loop_disable_a: assert property (
    (wr_stb && ptr == `OFF_IRQ_MASK)
    |=> O_INPUT_LOOP_DISABLE == $past(wr_data[7]))
    else $error("loop disable not taken from write");
  hot_decode_a: assert property (
    ##1 O_HOT_LIMIT_C == 8'(45 + 5 * int'($past(q.cfg_a[7:6]))))
    else $error("hot limit decode wrong");
  warm_decode_a: assert property (
    ##1 O_WARM_LIMIT_C == 8'(35 + 5 * int'($past(q.cfg_a[5:4]))))
    else $error("warm limit decode wrong");
  cool_decode_a: assert property (
    ##1 O_COOL_LIMIT_C == 8'(5 * int'($past(q.cfg_a[3:2]))))
    else $error("cool limit decode wrong");
  cold_decode_a: assert property (
    ##1 O_COLD_LIMIT_C == 8'(-10 + 5 * int'($past(q.cfg_a[1:0]))))
    else $error("cold limit decode wrong");
  vmin_decode_a: assert property (
    ##1 O_INPUT_MIN_VOLTAGE_DV == 6'(40 + int'($past(q.cfg_b[7:5]))))
    else $error("input minimum voltage decode wrong");
  ilim_reserved_a: assert property (
    (q.cfg_b[4:2] >= 3'h4) |=> O_INPUT_CURRENT_LIMIT_MA == 9'd95)
    else $error("reserved current code not clamped");
  pq_current_a: assert property (
    q.cfg_b[1] |=> O_PRECHARGE_CURRENT_PCT == 5'd20)
    else $error("precharge current select wrong");
  otp_default_a: assert property (
    $rose(q.otp_loaded)
    |-> O_CHARGER_ENABLE == $past(I_CHARGER_ENABLE_OTP_DEFAULT))
    else $error("charger enable not loaded from default");
  vpq_decode_a: assert property (
    ##1 O_PRECHARGE_VOLTAGE_DV == 5'(23 + int'($past(q.cfg_c[7:5]))))
    else $error("precharge voltage decode wrong");
  term_decode_a: assert property (
    (q.cfg_c[4:3] == 2'h1) |=> O_TERM_CURRENT_PERMILLE == 8'd75)
    else $error("termination decode wrong");
  topoff_decode_a: assert property (
    ##1 O_TOPOFF_MINUTES == 6'(5 * int'($past(q.cfg_c[2:0]))))
    else $error("top-off decode wrong");
  irq_raise_a: assert property (
    (|(I_EVENT_FLAGS & ~q.mask[6:0])) |=> O_IRQ)
    else $error("unmasked flag did not raise interrupt");

endmodule

// file: i2c_host_model.sv
// serial bus host model that reaches the charger register bank
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/100ps
`include "charger_cfg_defines.svh"

module i2c_host_model (
  // clock
  input  wire logic i_clk,
  // bus lines
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  // idle bus, both lines released
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  // wait on falling edges, all line changes land there
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // one bit: data set mid low phase, line sampled mid high phase
  task automatic put_bit(input logic b, output logic s);
    o_scl = 1'b0;
    tick(5);
    o_sda_low = ~b;
    tick(5);
    o_scl = 1'b1;
    tick(5);
    s = i_sda;
    tick(5);
  endtask

  // start when first is 0, stop when first is 1
  task automatic cond(input logic first);
    o_scl = 1'b0;
    tick(5);
    o_sda_low = first;
    tick(5);
    o_scl = 1'b1;
    tick(10);
    o_sda_low = ~first;
    tick(10);
  endtask

  // one byte, msb first, returns what the line carried
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) put_bit(d[i], q[i]);
  endtask

  // full write of one byte, ack is 1 only if every byte was acked
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] d, output logic ack);
    logic [7:0] q;
    logic       s0;
    logic       s1;
    logic       s2;
    cond(1'b0);
    xfer({dev, 1'b0}, q);
    put_bit(1'b1, s0);
    xfer(ptr, q);
    put_bit(1'b1, s1);
    xfer(d, q);
    put_bit(1'b1, s2);
    cond(1'b1);
    ack = ~(s0 | s1 | s2);
  endtask

  // pointer write, repeated start, one byte read, host nack
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d);
    logic [7:0] q;
    logic       s;
    cond(1'b0);
    xfer({`I2C_DEV_ADDR, 1'b0}, q);
    put_bit(1'b1, s);
    xfer(ptr, q);
    put_bit(1'b1, s);
    cond(1'b0);
    xfer({`I2C_DEV_ADDR, 1'b1}, q);
    put_bit(1'b1, s);
    xfer(8'hFF, d);
    put_bit(1'b1, s);
    cond(1'b1);
  endtask

  // read from the current pointer, host acks the first byte only
  task automatic read_two(output logic [7:0] d0, output logic [7:0] d1);
    logic [7:0] q;
    logic       s;
    cond(1'b0);
    xfer({`I2C_DEV_ADDR, 1'b1}, q);
    put_bit(1'b1, s);
    xfer(8'hFF, d0);
    put_bit(1'b0, s);
    xfer(8'hFF, d1);
    put_bit(1'b1, s);
    cond(1'b1);
  endtask
endmodule

// file: charger_config_irq_mask_regs_bench.sv
// self-checking bench for the charger mask and configuration bank
// assumes the host model file and the shared defines header
`timescale 1ns/100ps
`include "charger_cfg_defines.svh"

module charger_config_irq_mask_regs_bench;
  logic              clk;
  logic              rst_b;
  logic              otp;
  logic [6:0]        flags;
  logic              scl;
  logic              sda_low;
  logic              sda_out;
  logic              sda_oe_b;
  wire               sda_line;
  logic              irq;
  logic              loop_dis;
  logic              charger_enable;
  logic signed [7:0] hot;
  logic signed [7:0] warm;
  logic signed [7:0] cool;
  logic signed [7:0] cold;
  logic [5:0]        vmin;
  logic [8:0]        ilim;
  logic [4:0]        pq;
  logic [4:0]        vpq;
  logic [7:0]        term;
  logic [5:0]        topoff;
  int                num_errors;
  int                n_tests;
  int                cycles;

  // wired-and of both open-drain drivers with pull-up
  assign sda_line = ~sda_low & sda_oe_b;

  charger_config_irq_mask_regs u_dut (
    .I_SYS_CLK(clk), .I_RST_B(rst_b), .I_SCL(scl), .I_SDA(sda_line),
    .O_SDA_OUT(sda_out), .O_SDA_OE_B(sda_oe_b), .I_EVENT_FLAGS(flags),
    .I_CHARGER_ENABLE_OTP_DEFAULT(otp), .O_IRQ(irq),
    .O_INPUT_LOOP_DISABLE(loop_dis), .O_CHARGER_ENABLE(charger_enable),
    .O_HOT_LIMIT_C(hot), .O_WARM_LIMIT_C(warm), .O_COOL_LIMIT_C(cool),
    .O_COLD_LIMIT_C(cold), .O_INPUT_MIN_VOLTAGE_DV(vmin),
    .O_INPUT_CURRENT_LIMIT_MA(ilim), .O_PRECHARGE_CURRENT_PCT(pq),
    .O_PRECHARGE_VOLTAGE_DV(vpq), .O_TERM_CURRENT_PERMILLE(term),
    .O_TOPOFF_MINUTES(topoff)
  );

  i2c_host_model u_host (
    .i_clk(clk), .i_sda(sda_line), .o_scl(scl), .o_sda_low(sda_low)
  );

  // clock of 100 ns period
  always #50 clk = ~clk;

  // verdict and end of run
  task automatic report_and_stop();
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // hang guard, about two and a half times the expected run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      num_errors++;
      report_and_stop();
    end
  end

  // one comparison
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // register write and read through the serial port
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic ack;
    u_host.write_reg(`I2C_DEV_ADDR, ptr, d, ack);
    check(16'(ack), 16'h0001);
  endtask

  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] d;
    u_host.read_reg(ptr, d);
    check(16'(d), 16'(exp));
  endtask

  // reset held 20 cycles with a chosen one-time default
  task automatic do_reset(input logic v);
    otp   = v;
    rst_b = 1'b0;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    repeat (10) @(negedge clk);
  endtask

  // reset values of registers and decoded outputs, flags all masked
  // also a two-byte read that leans on the pointer left by the last read
  task automatic test_reset();
    logic [7:0] d0;
    logic [7:0] d1;
    check(16'(irq), 16'h0000);
    check(16'(sda_out), 16'h0000);
    rd(`OFF_IRQ_MASK, 8'h7F);
    rd(`OFF_TEMP_THRESH, 8'h0F);
    u_host.read_two(d0, d1);
    check(16'(d0), 16'h0001);
    check(16'(d1), 16'h00F8);
    rd(`OFF_INPUT_LIMITS, 8'h01);
    rd(`OFF_PRECHG_TERM, 8'hF8);
    check(16'(loop_dis), 16'h0000);
    check(16'(charger_enable), 16'h0001);
    check(16'(vpq), 16'd30);
    check(16'(topoff), 16'h0000);
  endtask

  // every code of the four temperature limits
  task automatic test_temp();
    logic [7:0] e;
    for (int c = 0; c < 4; c++) begin
      wr(`OFF_TEMP_THRESH, {c[1:0], c[1:0], c[1:0], c[1:0]});
      check(16'(hot), 16'(45 + 5 * c));
      check(16'(warm), 16'(35 + 5 * c));
      check(16'(cool), 16'(5 * c));
      e = 8'(5 * c - 10);
      check(16'($unsigned(cold)), 16'(e));
    end
  endtask

  // every code of voltage, current limit, reserved codes included
  task automatic test_limits();
    for (int c = 0; c < 8; c++) begin
      wr(`OFF_INPUT_LIMITS, {c[2:0], c[2:0], c[0], c[1]});
      check(16'(vmin), 16'(40 + c));
      check(16'(ilim), 16'((c > 4) ? 95 : 475 - 95 * c));
      check(16'(pq), 16'(c[0] ? 20 : 10));
      check(16'(charger_enable), 16'(c[1]));
      rd(`OFF_INPUT_LIMITS, {c[2:0], c[2:0], c[0], c[1]});
    end
  endtask

  // every code of precharge voltage, termination and top-off
  task automatic test_precharge();
    logic [15:0] term_tab [4];
    term_tab = '{16'd50, 16'd75, 16'd100, 16'd150};
    for (int c = 0; c < 8; c++) begin
      wr(`OFF_PRECHG_TERM, {c[2:0], c[1:0], c[2:0]});
      check(16'(vpq), 16'(23 + c));
      check(16'(term), term_tab[c[1:0]]);
      check(16'(topoff), 16'(5 * c));
    end
  endtask

  // each flag alone unmasked, all others masked and raised
  task automatic test_irq();
    for (int i = 0; i < 7; i++) begin
      wr(`OFF_IRQ_MASK, 8'h7F & ~(8'h01 << i));
      check(16'(loop_dis), 16'h0000);
      flags = ~(7'h01 << i);
      repeat (3) @(negedge clk);
      check(16'(irq), 16'h0000);
      flags = 7'h01 << i;
      repeat (3) @(negedge clk);
      check(16'(irq), 16'h0001);
      flags = 7'h00;
      repeat (3) @(negedge clk);
      check(16'(irq), 16'h0000);
    end
    wr(`OFF_IRQ_MASK, 8'h80);
    check(16'(loop_dis), 16'h0001);
    rd(`OFF_IRQ_MASK, 8'h80);
  endtask

  // foreign address ignored, unmapped offset reads zero
  task automatic test_refuse();
    logic ack;
    u_host.write_reg(`I2C_DEV_ADDR ^ 7'h01, `OFF_IRQ_MASK, 8'h00, ack);
    check(16'(ack), 16'h0000);
    rd(`OFF_IRQ_MASK, 8'h80);
    wr(8'h30, 8'h55);
    rd(8'h30, 8'h00);
  endtask

  // second reset in mid-run with the one-time default cleared
  task automatic test_otp();
    flags = 7'h7F;
    do_reset(1'b0);
    check(16'(charger_enable), 16'h0000);
    check(16'(irq), 16'h0000);
    rd(`OFF_INPUT_LIMITS, 8'h00);
  endtask

  // main sequence
  initial begin
    clk        = 1'b0;
    rst_b      = 1'b0;
    otp        = 1'b1;
    flags      = 7'h7F;
    num_errors = 0;
    n_tests    = 0;
    cycles     = 0;
    do_reset(1'b1);
    test_reset();
    test_temp();
    test_limits();
    test_precharge();
    test_irq();
    test_refuse();
    test_otp();
    report_and_stop();
  end
endmodule
